// ---- cpr_map.svh ----
// Offsets, field positions, reset values and timing figures of the clock ratio and protection block
`ifndef CPR_MAP_SVH
`define CPR_MAP_SVH

`define CPR_CFG_ADDR         8'h00
`define CPR_CFG_RESET        8'h63
`define CPR_MCLK_SEL_LSB      0
`define CPR_MCLK_SEL_MSB      2
`define CPR_INTERP_SEL_LSB    3
`define CPR_INTERP_SEL_MSB    4
`define CPR_THERM_REC_BYP_BIT 5
`define CPR_THERM_ADJ_BYP_BIT 6
`define CPR_FAULT_REC_BYP_BIT 7

`define CPR_CLK_HZ           40000000
`define CPR_TW_QUAL_MS       400
// Divide first: the plain product would overflow a 32-bit integer
`define CPR_TW_QUAL_CYC      (`CPR_TW_QUAL_MS * (`CPR_CLK_HZ / 1000))
`define CPR_TICK_NS          100000
`define CPR_TICK_CYC         ((`CPR_TICK_NS * (`CPR_CLK_HZ / 1000000)) / 1000)
`define CPR_HOLD_MIN_TICKS   16'h0001
`define CPR_HOLD_MAX_TICKS   16'h2710

`define CPR_PLL_HZ_32K       32'h01f40000
`define CPR_PLL_HZ_44K1      32'h02b11000
`define CPR_PLL_HZ_48K       32'h02ee0000

`endif

// ---- cpr_pkg.sv ----
// Types shared by the clock ratio and protection block
`default_nettype none
package cpr_pkg;
    typedef enum logic [1:0] {
        CPR_STAGE_OVERSAMPLE = 2'h0,
        CPR_STAGE_PASS       = 2'h1,
        CPR_STAGE_DOWNSAMPLE = 2'h2
    } cpr_stage_e;

    typedef enum logic [1:0] {
        CPR_FS_32K  = 2'h0,
        CPR_FS_44K1 = 2'h1,
        CPR_FS_48K  = 2'h2
    } cpr_fs_family_e;

    typedef enum logic [1:0] {
        CPR_FLT_IDLE    = 2'h0,
        CPR_FLT_HOLD    = 2'h1,
        CPR_FLT_RELEASE = 2'h3
    } cpr_fault_state_e;
endpackage : cpr_pkg
`default_nettype wire

// ---- cpr_tick.sv ----
// Free-running divider that gives a one-cycle enable every PERIOD core clocks
`timescale 1ns/1ps
`default_nettype none
module cpr_tick #(
    parameter int unsigned PERIOD = 4000
) (
    input  wire logic core_clk,
    input  wire logic reset_n,
    output logic      tick
);
    localparam int unsigned W = $clog2(PERIOD);
    localparam logic [W-1:0] LAST = W'(PERIOD - 1);

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    always_comb begin
        cnt_nxt = (cnt_r == LAST) ? '0 : W'(cnt_r + 1'b1);
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign tick = (cnt_r == LAST);
endmodule : cpr_tick
`default_nettype wire

// ---- cpr_core.sv ----
// Configuration register A, clock ratio decode, thermal limiting and fault recovery sequencing
`timescale 1ns/1ps
`default_nettype none
`include "cpr_map.svh"
module cpr_core #(
    parameter int unsigned TW_QUAL_CYC = `CPR_TW_QUAL_CYC,
    parameter int unsigned COEF_W      = 24
) (
    input  wire logic                   core_clk,
    input  wire logic                   reset_n,
    input  wire logic                   cfg_wr_en,
    input  wire logic [7:0]             cfg_addr,
    input  wire logic [7:0]             cfg_wdata,
    output logic      [7:0]             cfg_rdata,
    input  wire logic [1:0]             fs_family,
    input  wire logic                   thermal_warn_n,
    input  wire logic                   fault_n,
    input  wire logic [15:0]            fault_recovery_const,
    input  wire logic [COEF_W-1:0]      thermal_limit_coef,
    output logic      [9:0]             mclk_ratio,
    output logic                        mclk_ratio_valid,
    output logic      [31:0]            pll_target_hz,
    output cpr_pkg::cpr_stage_e         stage_mode,
    output logic                        limit_active,
    output logic      [COEF_W-1:0]      limit_coef,
    output logic                        pwr_tristate_n
);
    localparam logic [23:0] QUAL = 24'(TW_QUAL_CYC);

    // Ratio in units of fs; zero marks an unavailable combination
    function automatic logic [9:0] ratio_of(input logic [2:0] sel, input logic [1:0] rate);
        logic [9:0] base;
        base = 10'h000;
        unique case (sel)
            3'h5:    base = 10'h240;
            3'h4:    base = 10'h080;
            3'h3:    base = 10'h100;
            3'h2:    base = 10'h180;
            3'h1:    base = 10'h200;
            3'h0:    base = 10'h300;
            default: base = 10'h000;
        endcase
        if (sel == 3'h5 && rate != 2'h0) begin
            base = 10'h000;
        end
        if (rate == 2'h0) begin
            ratio_of = base;
        end else if (rate == 2'h1) begin
            ratio_of = base >> 1;
        end else begin
            ratio_of = base >> 2;
        end
    endfunction : ratio_of

    function automatic logic [15:0] hold_of(input logic [15:0] k);
        if (k < `CPR_HOLD_MIN_TICKS) begin
            hold_of = `CPR_HOLD_MIN_TICKS;
        end else if (k > `CPR_HOLD_MAX_TICKS) begin
            hold_of = `CPR_HOLD_MAX_TICKS;
        end else begin
            hold_of = k;
        end
    endfunction : hold_of

    logic [7:0]  cfg_r, cfg_nxt, rdata_r, rdata_nxt;
    logic [9:0]  ratio_r, ratio_nxt;
    logic        valid_r, valid_nxt;
    logic [31:0] pll_r, pll_nxt;
    cpr_pkg::cpr_stage_e stage_r, stage_nxt;

    wire logic       thermal_recovery_bypass = cfg_r[`CPR_THERM_REC_BYP_BIT];
    wire logic       thermal_adjust_bypass   = cfg_r[`CPR_THERM_ADJ_BYP_BIT];
    wire logic       fault_recovery_bypass   = cfg_r[`CPR_FAULT_REC_BYP_BIT];
    wire logic [1:0] interp_ratio_sel        = cfg_r[`CPR_INTERP_SEL_MSB:`CPR_INTERP_SEL_LSB];
    wire logic [2:0] mclk_ratio_sel          = cfg_r[`CPR_MCLK_SEL_MSB:`CPR_MCLK_SEL_LSB];

    always_comb begin
        cfg_nxt = cfg_r;
        if (cfg_wr_en && cfg_addr == `CPR_CFG_ADDR) begin
            cfg_nxt = cfg_wdata;
        end
        // Other addresses belong to neighbouring blocks and read as zero here
        rdata_nxt = (cfg_addr == `CPR_CFG_ADDR) ? cfg_r : 8'h00;
        ratio_nxt = ratio_of(mclk_ratio_sel, interp_ratio_sel);
        valid_nxt = (ratio_of(mclk_ratio_sel, interp_ratio_sel) != 10'h000);
        unique case (interp_ratio_sel)
            2'h0:    stage_nxt = cpr_pkg::CPR_STAGE_OVERSAMPLE;
            2'h1:    stage_nxt = cpr_pkg::CPR_STAGE_PASS;
            default: stage_nxt = cpr_pkg::CPR_STAGE_DOWNSAMPLE;
        endcase
        unique case (fs_family)
            cpr_pkg::CPR_FS_32K:  pll_nxt = `CPR_PLL_HZ_32K;
            cpr_pkg::CPR_FS_44K1: pll_nxt = `CPR_PLL_HZ_44K1;
            default:              pll_nxt = `CPR_PLL_HZ_48K;
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_r   <= `CPR_CFG_RESET;
            rdata_r <= 8'h00;
            ratio_r <= 10'h000;
            valid_r <= 1'b0;
            pll_r   <= `CPR_PLL_HZ_48K;
            stage_r <= cpr_pkg::CPR_STAGE_OVERSAMPLE;
        end else begin
            cfg_r   <= cfg_nxt;
            rdata_r <= rdata_nxt;
            ratio_r <= ratio_nxt;
            valid_r <= valid_nxt;
            pll_r   <= pll_nxt;
            stage_r <= stage_nxt;
        end
    end

    // Warning and fault come from the power stage, outside this clock
    logic warn_s1, warn_s2, flt_s1, flt_s2;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            warn_s1 <= 1'b1;
            warn_s2 <= 1'b1;
            flt_s1  <= 1'b1;
            flt_s2  <= 1'b1;
        end else begin
            warn_s1 <= thermal_warn_n;
            warn_s2 <= warn_s1;
            flt_s1  <= fault_n;
            flt_s2  <= flt_s1;
        end
    end

    logic [23:0]       wcnt_r, wcnt_nxt;
    logic              lim_r, lim_nxt;
    logic [COEF_W-1:0] coef_r, coef_nxt;
    wire logic         warn_qual = (wcnt_r >= QUAL);

    always_comb begin
        wcnt_nxt = wcnt_r;
        if (warn_s2) begin
            wcnt_nxt = 24'h000000;
        end else if (!warn_qual) begin
            wcnt_nxt = 24'(wcnt_r + 1'b1);
        end
        lim_nxt  = lim_r;
        coef_nxt = coef_r;
        if (thermal_adjust_bypass) begin
            lim_nxt = 1'b0;
        end else if (warn_qual) begin
            lim_nxt  = 1'b1;
            coef_nxt = thermal_limit_coef;
        end else if (warn_s2 && !thermal_recovery_bypass && !fault_recovery_bypass) begin
            // With bit 5 or bit 7 set the limit is held; clearing both bits later releases it
            lim_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wcnt_r <= 24'h000000;
            lim_r  <= 1'b0;
            coef_r <= '0;
        end else begin
            wcnt_r <= wcnt_nxt;
            lim_r  <= lim_nxt;
            coef_r <= coef_nxt;
        end
    end

    logic tick;
    cpr_tick #(.PERIOD(`CPR_TICK_CYC)) u_tick (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .tick     (tick)
    );

    cpr_pkg::cpr_fault_state_e st_r, st_nxt;
    logic [15:0] hcnt_r, hcnt_nxt;
    logic        tri_r, tri_nxt;

    always_comb begin
        st_nxt   = st_r;
        hcnt_nxt = hcnt_r;
        unique case (st_r)
            cpr_pkg::CPR_FLT_IDLE: begin
                if (!flt_s2 && !fault_recovery_bypass) begin
                    st_nxt   = cpr_pkg::CPR_FLT_HOLD;
                    hcnt_nxt = hold_of(fault_recovery_const);
                end
            end
            cpr_pkg::CPR_FLT_HOLD: begin
                if (tick) begin
                    hcnt_nxt = 16'(hcnt_r - 1'b1);
                    if (hcnt_r == 16'h0001) begin
                        st_nxt = cpr_pkg::CPR_FLT_RELEASE;
                    end
                end
            end
            cpr_pkg::CPR_FLT_RELEASE: begin
                // High for one tick so the power stage sees a clean release edge
                if (tick) begin
                    if (!flt_s2) begin
                        st_nxt   = cpr_pkg::CPR_FLT_HOLD;
                        hcnt_nxt = hold_of(fault_recovery_const);
                    end else begin
                        st_nxt = cpr_pkg::CPR_FLT_IDLE;
                    end
                end
            end
            default: st_nxt = cpr_pkg::CPR_FLT_IDLE;
        endcase
        if (fault_recovery_bypass) begin
            st_nxt = cpr_pkg::CPR_FLT_IDLE;
        end
        tri_nxt = (st_nxt != cpr_pkg::CPR_FLT_HOLD);
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r   <= cpr_pkg::CPR_FLT_IDLE;
            hcnt_r <= 16'h0000;
            tri_r  <= 1'b1;
        end else begin
            st_r   <= st_nxt;
            hcnt_r <= hcnt_nxt;
            tri_r  <= tri_nxt;
        end
    end

    assign cfg_rdata        = rdata_r;
    assign mclk_ratio       = ratio_r;
    assign mclk_ratio_valid = valid_r;
    assign pll_target_hz    = pll_r;
    assign stage_mode       = stage_r;
    assign limit_active     = lim_r;
    assign limit_coef       = coef_r;
    assign pwr_tristate_n   = tri_r;

    a_ratio_base256: assert property (@(posedge core_clk) disable iff (!reset_n)
        (mclk_ratio_sel == 3'h3 && interp_ratio_sel == 2'h0) ##1
        (mclk_ratio_sel == 3'h3 && interp_ratio_sel == 2'h0) |-> mclk_ratio == 10'h100)
        else $error("ratio for code 011 at base rate is not 256");
    a_ratio_quarter: assert property (@(posedge core_clk) disable iff (!reset_n)
        (mclk_ratio_sel == 3'h0 && interp_ratio_sel == 2'h2) |=> (mclk_ratio == 10'h0c0 && mclk_ratio_valid))
        else $error("quad rate ratio for code 000 is not 192");
    a_ratio_na: assert property (@(posedge core_clk) disable iff (!reset_n)
        (mclk_ratio_sel == 3'h5 && interp_ratio_sel != 2'h0) |=> !mclk_ratio_valid)
        else $error("code 101 accepted at a higher rate");
    a_pll_target: assert property (@(posedge core_clk) disable iff (!reset_n)
        (fs_family == cpr_pkg::CPR_FS_44K1) |=> pll_target_hz == 32'h02b11000)
        else $error("wrong internal clock for 44.1 kHz family");
    a_cfg_write: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cfg_wr_en && cfg_addr == 8'h00) |=> ##1 (cfg_rdata == $past(cfg_wdata, 2) || $past(cfg_wr_en)))
        else $error("register write not seen on read data");
    a_stage_pass: assert property (@(posedge core_clk) disable iff (!reset_n)
        interp_ratio_sel == 2'h1 |=> stage_mode == cpr_pkg::CPR_STAGE_PASS)
        else $error("pass-through not selected for code 01");
    a_limit_bypass: assert property (@(posedge core_clk) disable iff (!reset_n)
        thermal_adjust_bypass |=> !limit_active)
        else $error("limit applied while adjustment bypassed");
    a_limit_set: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!thermal_adjust_bypass && wcnt_r == QUAL) |=> (limit_active && limit_coef == $past(thermal_limit_coef)))
        else $error("limit not applied after qualified warning");
    a_limit_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
        (limit_active && !thermal_adjust_bypass && (thermal_recovery_bypass || fault_recovery_bypass))
        |=> limit_active)
        else $error("limit dropped while recovery bypassed");
    // The count is still qualified in the first cycle after the warning clears, and the set wins there
    a_limit_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
        (limit_active && !thermal_adjust_bypass && !thermal_recovery_bypass && !fault_recovery_bypass
         && warn_s2 && !warn_qual) |=> !limit_active)
        else $error("limit kept after warning cleared");
    a_fault_start: assert property (@(posedge core_clk) disable iff (!reset_n)
        (st_r == cpr_pkg::CPR_FLT_IDLE && !flt_s2 && !fault_recovery_bypass) |=> !pwr_tristate_n)
        else $error("fault did not pull tristate low");
    a_fault_bypass: assert property (@(posedge core_clk) disable iff (!reset_n)
        fault_recovery_bypass |=> pwr_tristate_n)
        else $error("recovery ran while bypassed");
endmodule : cpr_core
`default_nettype wire

// ---- cpr_pstage_model.sv ----
// Behavioural model of the power output stage feeding warning and fault lines back
`timescale 1ns/1ps
`default_nettype none
module cpr_pstage_model (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic hot,
    input  wire logic short_ckt,
    input  wire logic heal,
    input  wire logic pwr_tristate_n,
    output logic      thermal_warn_n,
    output logic      fault_n
);
    // The master clock is assumed to be an integer multiple of fs
    localparam int unsigned MCLK_HZ = 256 * 48000;
    logic cured_r;

    // A healing fault clears only after the stage has been sent through a recovery
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cured_r <= 1'b0;
        end else if (!short_ckt) begin
            cured_r <= 1'b0;
        end else if (heal && !pwr_tristate_n) begin
            cured_r <= 1'b1;
        end
    end

    assign fault_n        = !(short_ckt && !cured_r);
    assign thermal_warn_n = !hot;
endmodule : cpr_pstage_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the clock ratio and protection block
`timescale 1ns/1ps
`default_nettype none
`include "cpr_map.svh"
module testbench;
    typedef struct {int sel; logic [31:0] exp;} cpr_note_s;
    logic                core_clk = 1'b0;
    logic                reset_n = 1'b0;
    logic                cfg_wr_en = 1'b0;
    logic [7:0]          cfg_addr = 8'h00;
    logic [7:0]          cfg_wdata = 8'h00;
    logic [7:0]          cfg_rdata;
    logic [1:0]          fs_family = 2'h0;
    logic                thermal_warn_n;
    logic                fault_n;
    logic [15:0]         fault_recovery_const = 16'h0002;
    logic [23:0]         thermal_limit_coef = 24'h000000;
    logic [9:0]          mclk_ratio;
    logic                mclk_ratio_valid;
    logic [31:0]         pll_target_hz;
    cpr_pkg::cpr_stage_e stage_mode;
    logic                limit_active;
    logic [23:0]         limit_coef;
    logic                pwr_tristate_n;
    logic                hot = 1'b0;
    logic                short_ckt = 1'b0;
    logic                heal = 1'b0;
    logic                span_ok = 1'b0;
    int                  error_cnt = 0;
    int                  tests_run = 0;
    int                  span;
    cpr_note_s           q[$];
    event                look;
    logic [31:0]         base [8] = '{32'h300, 32'h200, 32'h180, 32'h100, 32'h80, 32'h240, 32'h0, 32'h0};
    string               what [9] = '{"cfg_rdata", "mclk_ratio", "mclk_ratio_valid", "pll_target_hz",
                                      "stage_mode", "limit_active", "limit_coef", "pwr_tristate_n", "span"};

    always #12.5 core_clk = ~core_clk;

    cpr_core #(.TW_QUAL_CYC(50)) cpr_core_i (
        .core_clk(core_clk), .reset_n(reset_n), .cfg_wr_en(cfg_wr_en), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .fs_family(fs_family),
        .thermal_warn_n(thermal_warn_n), .fault_n(fault_n), .fault_recovery_const(fault_recovery_const),
        .thermal_limit_coef(thermal_limit_coef), .mclk_ratio(mclk_ratio), .mclk_ratio_valid(mclk_ratio_valid),
        .pll_target_hz(pll_target_hz), .stage_mode(stage_mode), .limit_active(limit_active),
        .limit_coef(limit_coef), .pwr_tristate_n(pwr_tristate_n));

    cpr_pstage_model cpr_pstage_model_i (
        .core_clk(core_clk), .reset_n(reset_n), .hot(hot), .short_ckt(short_ckt), .heal(heal),
        .pwr_tristate_n(pwr_tristate_n), .thermal_warn_n(thermal_warn_n), .fault_n(fault_n));

    function automatic logic [31:0] act(int s);
        case (s)
            0: return {24'h0, cfg_rdata};
            1: return {22'h0, mclk_ratio};
            2: return {31'h0, mclk_ratio_valid};
            3: return pll_target_hz;
            4: return {30'h0, stage_mode};
            5: return {31'h0, limit_active};
            6: return {8'h0, limit_coef};
            7: return {31'h0, pwr_tristate_n};
            default: return {31'h0, span_ok};
        endcase
    endfunction : act

    task automatic check(logic [31:0] seen, logic [31:0] exp, string name);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic note(int s, logic [31:0] v);
        q.push_back('{s, v});
        -> look;
    endtask : note

    task automatic cyc(int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge core_clk);
        cfg_wr_en = 1'b1;
        cfg_addr  = a;
        cfg_wdata = d;
        @(negedge core_clk);
        cfg_wr_en = 1'b0;
        cfg_addr  = 8'h00;
        @(negedge core_clk);
    endtask : wr

    // Waits for the next recovery pulse, then measures how long it stays low
    task automatic low_span(int lo, int hi);
        int w;
        w    = 0;
        span = 0;
        while (pwr_tristate_n !== 1'b0 && w < 9000) begin
            cyc(1);
            w++;
        end
        while (pwr_tristate_n === 1'b0 && span < 9000) begin
            cyc(1);
            span++;
        end
        span_ok = (span > lo) && (span <= hi);
        note(8, 32'h1);
    endtask : low_span

    task automatic summarize();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    initial begin : monitor
        cpr_note_s n;
        forever begin
            @(look);
            while (q.size() > 0) begin
                n = q.pop_front();
                check(act(n.sel), n.exp, what[n.sel]);
            end
        end
    end

    initial begin : watchdog
        #(25 * 90000);
        error_cnt++;
        summarize();
    end

    initial begin : main
        logic [7:0]  v;
        logic [31:0] e;
        void'($urandom(32'h049e));
        cyc(16);
        thermal_limit_coef = 24'($urandom());
        reset_n = 1'b1;
        cyc(2);
        note(0, {24'h0, `CPR_CFG_RESET});
        note(1, 32'h100);
        note(4, 32'h0);
        for (int i = 0; i < 32; i++) begin
            v = {3'($urandom()), i[4:0]};
            wr(`CPR_CFG_ADDR, v);
            fs_family = i[1:0];
            e = (v[4:3] != 2'h0 && v[2:0] == 3'h5) ? 32'h0 : base[v[2:0]] >> (v[4] ? 2 : v[3]);
            note(0, {24'h0, v});
            note(1, e);
            note(2, {31'h0, e != 32'h0});
            note(4, v[4] ? 32'h2 : {31'h0, v[3]});
            cyc(2);
            note(3, i[1:0] == 2'h0 ? `CPR_PLL_HZ_32K : i[1:0] == 2'h1 ? `CPR_PLL_HZ_44K1 : `CPR_PLL_HZ_48K);
        end
        // An unmapped write must leave the configuration byte alone
        wr(`CPR_CFG_ADDR, 8'h0b);
        wr(8'h05, 8'hff);
        note(0, 32'h0b);
        note(1, 32'h80);
        cfg_addr = 8'h05;
        cyc(1);
        note(0, 32'h0);
        cfg_addr = 8'h00;
        // A short warning restarts the qualification count
        hot = 1'b1;
        cyc(30);
        hot = 1'b0;
        cyc(5);
        hot = 1'b1;
        cyc(45);
        note(5, 32'h0);
        cyc(15);
        note(5, 32'h1);
        note(6, {8'h0, thermal_limit_coef});
        hot = 1'b0;
        cyc(8);
        note(5, 32'h0);
        for (int k = 0; k < 2; k++) begin
            wr(`CPR_CFG_ADDR, k == 0 ? 8'h2b : 8'h8b);
            hot = 1'b1;
            cyc(60);
            note(5, 32'h1);
            hot = 1'b0;
            cyc(8);
            note(5, 32'h1);
        end
        wr(`CPR_CFG_ADDR, 8'hcb);
        cyc(2);
        note(5, 32'h0);
        hot = 1'b1;
        cyc(60);
        note(5, 32'h0);
        hot = 1'b0;
        wr(`CPR_CFG_ADDR, 8'h0b);
        cyc(2);
        note(5, 32'h0);
        // Persistent fault: repeated pulses of two ticks
        short_ckt = 1'b1;
        cyc(4);
        note(7, 32'h0);
        low_span(3990, 8000);
        cyc(3990);
        note(7, 32'h1);
        low_span(4000, 8000);
        fault_recovery_const = 16'h0000;
        heal = 1'b1;
        low_span(0, 4000);
        cyc(8500);
        note(7, 32'h1);
        wr(`CPR_CFG_ADDR, 8'h8b);
        short_ckt = 1'b0;
        heal = 1'b0;
        cyc(2);
        short_ckt = 1'b1;
        cyc(200);
        note(7, 32'h1);
        wr(`CPR_CFG_ADDR, 8'h0b);
        cyc(10);
        note(7, 32'h0);
        wr(`CPR_CFG_ADDR, 8'h8b);
        note(7, 32'h1);
        cyc(2);
        summarize();
    end
endmodule : testbench
`default_nettype wire
